// >>> hw/shacc_top.sv
// hash accelerator control: apb registers, cpu and dma sequencing
// assumes an external round engine behind core_go/core_done and a dma
// word stream with valid/ready; the engine truncates 512/t digests
//
// Function
// - start hashes block from built-in constant
// - continue chains from current hash registers
// - busy reads 1 while a block runs
// - algorithm select and hash registers stay readable
// - written hash values become chaining state
// - start with mode 7 generates t IV
// - message registers writable during block hashing
// - dma mode takes data from dma stream
// - dma run hashes exactly programmed block count
// - dma start uses constant, continue chains
// - dma completion clears busy, raises interrupt
// - interrupt only for dma-mode completion
// - interrupt delivered only while enable set
// - interrupt stays until clear written with 1
// - digest fills word count of algorithm
// - first digest word in hash register 0
// - short digests left-justified from register 0
// - mode codes 0 to 7 select algorithm
// - 512 or 1024 bit blocks, upper first
// - t string 32 bits, t length 7 bits
`timescale 1ns/1ns
module shacc_top
   import shacc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // dma word stream
   input wire logic dma_valid,
   input wire logic [DATA_W-1:0] dma_data,
   output logic dma_ready,
   // round engine
   output logic core_go,
   output shacc_core_req_t core_req,
   output logic [H_WORDS*DATA_W-1:0] core_chain,
   output logic [M_WORDS*DATA_W-1:0] core_block,
   output logic [DATA_W-1:0] core_t_string,
   output logic [TLEN_W-1:0] core_t_length,
   input wire logic core_done,
   input wire logic [H_WORDS*DATA_W-1:0] core_digest,
   // completion interrupt
   output logic done_irq
);
   // ********************
   // apb decode
   // ********************
   wire logic setup = psel && !penable;
   wire logic access = psel && penable;
   wire logic wr = access && pwrite;
   wire logic [7:0] ofs = paddr[7:0];
   wire logic aligned = (paddr[PADDR_W-1:8] == '0) && (paddr[1:0] == 2'h0);
   wire logic in_h = aligned && (ofs[7:6] == H_REGION);
   wire logic in_m = aligned && ofs[7];
   wire logic in_ctl = aligned && (ofs <= OFS_VERSION);
   wire logic mapped = in_h || in_m || in_ctl;
   wire logic [3:0] h_idx = ofs[5:2];
   wire logic [4:0] m_idx = ofs[6:2];
   wire logic cmd = pwdata[CMD_BIT];
   wire logic wr_ctl = wr && in_ctl;

   shacc_state_t state_q, state_d;
   logic [2:0] mode_q;
   logic [DATA_W-1:0] tstr_q;
   logic [TLEN_W-1:0] tlen_q;
   logic [BLK_CNT_W-1:0] blk_num_q;
   logic [BLK_CNT_W-1:0] left_q;
   logic irq_en_q;
   logic irq_q;
   logic [DATA_W-1:0] version_q;
   logic dma_q;
   logic go_q;
   shacc_core_req_t req_q;
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] h_q [H_WORDS];
   logic [DATA_W-1:0] m_q [M_WORDS];
   logic [M_WORDS*DATA_W-1:0] m_flat;
   logic [4:0] cnt;

   wire logic idle = (state_q == st_idle);
   wire logic busy = !idle;
   // one-cycle command strobes, nothing to write back
   wire logic start_wr = wr_ctl && (ofs == OFS_START) && cmd;
   wire logic cont_wr = wr_ctl && (ofs == OFS_CONT) && cmd;
   wire logic dstart_wr = wr_ctl && (ofs == OFS_DMA_START) && cmd;
   wire logic dcont_wr = wr_ctl && (ofs == OFS_DMA_CONT) && cmd;
   wire logic clr_wr = wr_ctl && (ofs == OFS_IRQ_CLEAR) && cmd;
   // start and continue commands take effect only when idle; irq clear does not wait
   wire logic go_start = start_wr && idle;
   wire logic go_cont = cont_wr && idle;
   // a zero block count would wrap and run 65536 blocks, so it is ignored
   wire logic blk_nz = (blk_num_q != '0);
   wire logic go_dma = (dstart_wr || dcont_wr) && idle && blk_nz;
   wire logic cfg_ok = wr_ctl && idle;

   // ********************
   // sequencing
   // ********************
   wire logic wide = shacc_wide(mode_q);
   wire logic [4:0] last_idx = wide ? LAST_WIDE : LAST_NARROW;
   wire logic push = (state_q == st_fetch) && dma_valid;
   wire logic blk_last = push && (cnt == last_idx);
   wire logic hash_done = (state_q == st_hash) && core_done;
   wire logic more = dma_q && (left_q != BLK_ONE);
   wire logic run_end = hash_done && dma_q && !more;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         st_idle: begin
            if (go_start || go_cont) begin
               state_d = st_hash;
            end else if (go_dma) begin
               state_d = st_fetch;
            end
         end
         st_fetch: begin
            if (blk_last) begin
               state_d = st_hash;
            end
         end
         st_hash: begin
            if (core_done) begin
               state_d = more ? st_fetch : st_idle;
            end
         end
         default: state_d = st_idle;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= st_idle;
         go_q <= 1'b0;
      end else begin
         state_q <= state_d;
         go_q <= (state_d == st_hash) && (state_q != st_hash);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_q <= '0;
         dma_q <= 1'b0;
         left_q <= '0;
      end else if (go_start) begin
         req_q <= '{mode: mode_q, from_iv: 1'b1, iv_gen: mode_q == MODE_SHA512_T};
         dma_q <= 1'b0;
      end else if (go_cont) begin
         req_q <= '{mode: mode_q, from_iv: 1'b0, iv_gen: 1'b0};
         dma_q <= 1'b0;
      end else if (go_dma) begin
         req_q <= '{mode: mode_q, from_iv: dstart_wr, iv_gen: 1'b0};
         dma_q <= 1'b1;
         left_q <= blk_num_q;
      end else if (hash_done) begin
         // later blocks of a run always chain
         req_q.from_iv <= 1'b0;
         req_q.iv_gen <= 1'b0;
         left_q <= dma_q ? left_q - BLK_ONE : left_q;
      end
   end

   // ********************
   // message and working block
   // ********************
   for (genvar i = 0; i < M_WORDS; i++) begin : g_mflat
      assign m_flat[(M_WORDS-1-i)*DATA_W +: DATA_W] = m_q[i];
   end

   // snapshot at launch frees the message registers for the next block
   shacc_blk_buf #(.WORDS(M_WORDS), .W(DATA_W)) u_blk (
      .clk(core_clk),
      .reset(reset),
      .snap(go_start || go_cont),
      .snap_data(m_flat),
      .push(push),
      .push_data(dma_data),
      .restart(go_dma || blk_last),
      .cnt(cnt),
      .blk(core_block)
   );

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < M_WORDS; i++) begin
            m_q[i] <= '0;
         end
      end else if (wr && in_m) begin
         m_q[m_idx] <= pwdata;
      end
   end

   // ********************
   // hash registers
   // ********************
   wire logic [4:0] dig_words = req_q.iv_gen ? 5'h10 : shacc_digest_words(req_q.mode);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < H_WORDS; i++) begin
            h_q[i] <= '0;
         end
      end else if (hash_done) begin
         for (int i = 0; i < H_WORDS; i++) begin
            // engine word 0 is the top slice, left-justified
            if (5'(i) < dig_words) begin
               h_q[i] <= core_digest[(H_WORDS-1-i)*DATA_W +: DATA_W];
            end
         end
      end else if (wr && in_h && idle) begin
         h_q[h_idx] <= pwdata;
      end
   end

   for (genvar i = 0; i < H_WORDS; i++) begin : g_chain
      assign core_chain[(H_WORDS-1-i)*DATA_W +: DATA_W] = h_q[i];
   end

   // ********************
   // configuration and interrupt
   // ********************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_q <= MODE_RST;
         tstr_q <= TSTRING_RST;
         tlen_q <= TLENGTH_RST;
         blk_num_q <= BLK_NUM_RST;
         irq_en_q <= IRQ_EN_RST;
         version_q <= VERSION_RST;
      end else if (cfg_ok) begin
         // algorithm and t inputs are frozen while a block runs
         if (ofs == OFS_MODE) mode_q <= pwdata[2:0];
         if (ofs == OFS_TSTRING) tstr_q <= pwdata;
         if (ofs == OFS_TLENGTH) tlen_q <= pwdata[TLEN_W-1:0];
         if (ofs == OFS_BLK_NUM) blk_num_q <= pwdata[BLK_CNT_W-1:0];
         if (ofs == OFS_IRQ_ENABLE) irq_en_q <= pwdata[0];
         if (ofs == OFS_VERSION) version_q <= pwdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else if (run_end && irq_en_q) begin
         irq_q <= 1'b1;
      end else if (clr_wr) begin
         irq_q <= 1'b0;
      end
   end

   assign done_irq = irq_q && irq_en_q;

   // ********************
   // read path
   // ********************
   wire logic [DATA_W-1:0] ctl_rd =
      (ofs == OFS_MODE) ? {29'h0, mode_q} :
      (ofs == OFS_TSTRING) ? tstr_q :
      (ofs == OFS_TLENGTH) ? {25'h0, tlen_q} :
      (ofs == OFS_BLK_NUM) ? {16'h0, blk_num_q} :
      (ofs == OFS_BUSY) ? {31'h0, busy} :
      (ofs == OFS_IRQ_ENABLE) ? {31'h0, irq_en_q} :
      (ofs == OFS_VERSION) ? version_q : 32'h0;
   wire logic [DATA_W-1:0] rd_val = in_h ? h_q[h_idx] :
      in_m ? m_q[m_idx] : in_ctl ? ctl_rd : 32'h0;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         prdata_q <= '0;
      end else if (setup) begin
         prdata_q <= rd_val;
      end
   end

   assign prdata = prdata_q;
   assign pready = access;
   assign pslverr = access && !mapped;
   assign dma_ready = (state_q == st_fetch);
   assign core_go = go_q;
   assign core_req = req_q;
   assign core_t_string = tstr_q;
   assign core_t_length = tlen_q;

   // ********************
   // checks
   // ********************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_start_from_iv: assert property (go_start |=> req_q.from_iv && core_go)
      else $error("start did not launch from constant");
   a_cont_chains: assert property (go_cont |=> !req_q.from_iv && busy)
      else $error("continue did not chain");
   a_busy_drops: assert property (hash_done && !dma_q |=> !busy)
      else $error("busy stuck after cpu block");
   a_tgen_flag: assert property (go_start && mode_q == MODE_SHA512_T |=> req_q.iv_gen)
      else $error("t iv generation not requested");
   a_block_held: assert property ((state_q == st_hash) && $past(state_q == st_hash)
      |-> $stable(core_block))
      else $error("block changed while hashing");
   a_dma_count: assert property (hash_done && more |=> state_q == st_fetch)
      else $error("dma run ended early");
   a_irq_dma_only: assert property ($rose(irq_q) |-> $past(run_end))
      else $error("interrupt without dma completion");
   a_irq_gated: assert property (!irq_en_q |-> !done_irq)
      else $error("interrupt leaked while disabled");
   a_irq_holds: assert property (irq_q && !clr_wr |=> irq_q)
      else $error("interrupt dropped without clear");
   a_busy_ignore: assert property (busy && (start_wr || cont_wr)
      |=> $stable(req_q.mode) && busy)
      else $error("busy command not ignored");

   c_cpu_block: cover property (go_start ##[1:50] (hash_done && !dma_q));
   c_dma_run: cover property (go_dma ##[1:500] run_end);
   c_tgen: cover property (go_start && mode_q == MODE_SHA512_T);
   c_irq_clear: cover property (irq_q && clr_wr);
endmodule

// >>> hw/shacc_pkg.sv
// shared constants, types and helpers for the hash accelerator control
// assumes a 32-bit apb register window and an external round engine
package shacc_pkg;
   // ********************
   // widths
   // ********************
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PADDR_W = 12;
   localparam int unsigned H_WORDS = 16;
   localparam int unsigned M_WORDS = 32;
   localparam int unsigned BLK_CNT_W = 16;
   localparam int unsigned TLEN_W = 7;
   localparam int unsigned CMD_BIT = 0;
   // ********************
   // register offsets
   // ********************
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_TSTRING = 8'h04;
   localparam logic [7:0] OFS_TLENGTH = 8'h08;
   localparam logic [7:0] OFS_BLK_NUM = 8'h0C;
   localparam logic [7:0] OFS_START = 8'h10;
   localparam logic [7:0] OFS_CONT = 8'h14;
   localparam logic [7:0] OFS_BUSY = 8'h18;
   localparam logic [7:0] OFS_DMA_START = 8'h1C;
   localparam logic [7:0] OFS_DMA_CONT = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
   localparam logic [7:0] OFS_VERSION = 8'h2C;
   localparam logic [1:0] H_REGION = 2'h1;
   localparam logic [4:0] LAST_NARROW = 5'h0F;
   localparam logic [4:0] LAST_WIDE = 5'h1F;
   // ********************
   // algorithm codes
   // ********************
   localparam logic [2:0] MODE_SHA1 = 3'h0;
   localparam logic [2:0] MODE_SHA224 = 3'h1;
   localparam logic [2:0] MODE_SHA256 = 3'h2;
   localparam logic [2:0] MODE_SHA384 = 3'h3;
   localparam logic [2:0] MODE_SHA512 = 3'h4;
   localparam logic [2:0] MODE_SHA512_224 = 3'h5;
   localparam logic [2:0] MODE_SHA512_256 = 3'h6;
   localparam logic [2:0] MODE_SHA512_T = 3'h7;
   // ********************
   // reset values
   // ********************
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [31:0] TSTRING_RST = 32'h0000_0000;
   localparam logic [6:0] TLENGTH_RST = 7'h00;
   localparam logic [15:0] BLK_NUM_RST = 16'h0000;
   localparam logic IRQ_EN_RST = 1'b0;
   // value is arbitrary
   localparam logic [31:0] VERSION_RST = 32'h0000_0001;
   localparam logic [15:0] BLK_ONE = 16'h0001;
   // ********************
   // types
   // ********************
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_fetch = 2'b01,
      st_hash = 2'b11
   } shacc_state_t;
   typedef struct packed {
      logic [2:0] mode;
      logic from_iv;
      logic iv_gen;
   } shacc_core_req_t;
   // 64-bit word algorithms use 1024-bit blocks
   function automatic logic shacc_wide(input logic [2:0] m);
      return m >= MODE_SHA384;
   endfunction
   // count of 32-bit digest words written back
   function automatic logic [4:0] shacc_digest_words(input logic [2:0] m);
      logic [4:0] n;
      n = 5'h10;
      unique case (m)
         MODE_SHA1: n = 5'h05;
         MODE_SHA224: n = 5'h07;
         MODE_SHA256: n = 5'h08;
         MODE_SHA384: n = 5'h0C;
         MODE_SHA512: n = 5'h10;
         MODE_SHA512_224: n = 5'h07;
         MODE_SHA512_256: n = 5'h08;
         MODE_SHA512_T: n = 5'h10;
      endcase
      return n;
   endfunction
endpackage

// >>> hw/shacc_blk_buf.sv
// working block buffer: snapshot of message registers or dma word stream
// assumes the caller restarts the word count before each dma block
`timescale 1ns/1ns
module shacc_blk_buf #(
   parameter int unsigned WORDS = 32,
   parameter int unsigned W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // loading
   input wire logic snap,
   input wire logic [WORDS*W-1:0] snap_data,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic restart,
   // state
   output logic [$clog2(WORDS)-1:0] cnt,
   output logic [WORDS*W-1:0] blk
);
   localparam int unsigned CW = $clog2(WORDS);
   logic [CW-1:0] cnt_q;
   assign cnt = cnt_q;
   always_ff @(posedge clk) begin
      if (reset || restart || snap) begin
         cnt_q <= '0;
      end else if (push) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
   // word 0 sits in the top bits
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      logic [W-1:0] word_q;
      wire logic hit = push && (cnt_q == CW'(i));
      always_ff @(posedge clk) begin
         if (reset) begin
            word_q <= '0;
         end else if (snap) begin
            word_q <= snap_data[(WORDS-1-i)*W +: W];
         end else if (hit) begin
            word_q <= push_data;
         end
      end
      assign blk[(WORDS-1-i)*W +: W] = word_q;
   end
endmodule

// >>> verification/shacc_far_model.sv
// stand-in for the round engine and the crypto dma word stream
// assumes one core_go pulse per block and beats taken on valid and ready
`timescale 1ns/1ns
module shacc_far_model
   import shacc_pkg::*;
#(
   parameter int LAT = 20,
   parameter logic [31:0] IV_K = 32'h5A5A_0000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // engine side
   input wire logic core_go,
   input wire shacc_core_req_t core_req,
   input wire logic [H_WORDS*DATA_W-1:0] core_chain,
   input wire logic [M_WORDS*DATA_W-1:0] core_block,
   input wire logic [DATA_W-1:0] core_t_string,
   output logic core_done,
   output logic [H_WORDS*DATA_W-1:0] core_digest,
   // dma side
   input wire logic dma_ready,
   output logic dma_valid,
   output logic [DATA_W-1:0] dma_data,
   output int beats
);
   logic [H_WORDS*DATA_W-1:0] res_q = '0;
   logic done_q = 1'b0;
   logic ph_q = 1'b0;
   int cnt_q = 0;
   logic [H_WORDS*DATA_W-1:0] base;
   // ********************
   // outputs
   // ********************
   // digest bus is not held outside the done pulse
   assign core_digest = done_q ? res_q : ~res_q;
   assign core_done = done_q;
   // stream stalls every other cycle
   assign dma_valid = ph_q;
   assign dma_data = ph_q ? 32'hD000_0000 + beats : 32'h2FFF_FFFF - beats;
   assign base = core_req.iv_gen ? {16{core_t_string}} :
      core_req.from_iv ? {16{IV_K}} : core_chain;
   // ********************
   // behaviour
   // ********************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ph_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= 0;
      end else begin
         ph_q <= ~ph_q;
         if (dma_valid && dma_ready) beats <= beats + 1;
         done_q <= (cnt_q == 1);
         if (core_go) begin
            cnt_q <= LAT;
            res_q <= base ^ core_block[1023:512];
         end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the hash control block
// assumes zero-wait apb and the far model's digest and beat patterns
`timescale 1ns/1ns
module tb_top
   import shacc_pkg::*;
;
   localparam logic [31:0] IV_K = 32'h5A5A_0000;
   localparam logic [31:0] T_STR = 32'h3536_8000;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata, dma_data, core_t_string;
   logic pready, pslverr, dma_valid, dma_ready, core_go, core_done, done_irq;
   logic [TLEN_W-1:0] core_t_length;
   shacc_core_req_t core_req;
   logic [H_WORDS*DATA_W-1:0] core_chain, core_digest;
   logic [M_WORDS*DATA_W-1:0] core_block;
   int beats;
   int go_cnt = 0;
   int num_errors = 0;
   int comparisons = 0;
   logic [31:0] h_exp [16];
   int nw [8] = '{5, 7, 8, 12, 16, 7, 8, 16};
   shacc_top dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
      .core_go(core_go), .core_req(core_req), .core_chain(core_chain),
      .core_block(core_block), .core_t_string(core_t_string),
      .core_t_length(core_t_length), .core_done(core_done), .core_digest(core_digest),
      .done_irq(done_irq));
   shacc_far_model #(.LAT(20), .IV_K(IV_K)) far (.core_clk(core_clk), .reset(reset),
      .core_go(core_go), .core_req(core_req), .core_chain(core_chain),
      .core_block(core_block), .core_t_string(core_t_string), .core_done(core_done),
      .core_digest(core_digest), .dma_ready(dma_ready), .dma_valid(dma_valid),
      .dma_data(dma_data), .beats(beats));
   initial forever #10 core_clk = ~core_clk;
   always @(posedge core_clk) if (core_go === 1'b1) go_cnt <= go_cnt + 1;
   // ********************
   // helpers
   // ********************
   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb({4'h0, a}, 1'b1, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb({4'h0, a}, 1'b0, 32'h0, r, e);
   endtask
   function automatic logic [7:0] wa(input logic [7:0] b, input int i);
      return b + 8'(i * 4);
   endfunction
   // bounded poll of the busy flag
   task automatic wait_idle();
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         rd(OFS_BUSY, r);
         n++;
      end while (r !== 32'h0 && n < 200);
      chk(r, 32'h0);
   endtask
   // ********************
   // scenarios
   // ********************
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd(OFS_MODE, r);
      chk(r, 32'h0);
      rd(OFS_VERSION, r);
      chk(r, VERSION_RST);
      apb(12'h100, 1'b0, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
   endtask
   // message is poked and the command repeated mid-block to prove both harmless
   task automatic run_cpu(input logic [2:0] md, input logic [7:0] cmd, input logic [31:0] s);
      logic [31:0] r;
      logic [31:0] base [16];
      int g;
      wr(OFS_MODE, {29'h0, md});
      for (int i = 0; i < 32; i++) wr(wa(8'h80, i), s + 32'(i));
      for (int i = 0; i < 16; i++) base[i] = (cmd == OFS_CONT) ? h_exp[i] :
         (md == MODE_SHA512_T) ? T_STR : IV_K;
      g = go_cnt;
      wr(cmd, 32'h1);
      rd(OFS_BUSY, r);
      chk(r, 32'h1);
      wr(8'h80, ~s);
      wr(cmd, 32'h1);
      wait_idle();
      chk(32'(go_cnt - g), 32'h1);
      for (int i = 0; i < 16; i++) begin
         if (i < nw[md]) h_exp[i] = base[i] ^ (s + 32'(i));
         rd(wa(8'h40, i), r);
         chk(r, h_exp[i]);
      end
      chk({31'h0, done_irq}, 32'h0);
   endtask
   task automatic t_modes();
      for (int i = 0; i < 16; i++) begin
         h_exp[i] = 32'h1111_0000 + 32'(i);
         wr(wa(8'h40, i), h_exp[i]);
      end
      wr(OFS_TSTRING, T_STR);
      wr(OFS_TLENGTH, 32'h50);
      for (int m = 0; m < 8; m++) run_cpu(3'(m), OFS_START, 32'hA000_0000 + 32'(m * 256));
      chk({25'h0, core_t_length}, 32'h50);
   endtask
   // save, run an inserted task, write back and resume
   task automatic t_resume();
      logic [31:0] r;
      logic [31:0] sv [16];
      rd(OFS_MODE, r);
      chk(r, 32'h7);
      for (int i = 0; i < 16; i++) begin
         rd(wa(8'h40, i), sv[i]);
         chk(sv[i], h_exp[i]);
      end
      run_cpu(MODE_SHA256, OFS_START, 32'hB000_0000);
      for (int i = 0; i < 16; i++) wr(wa(8'h40, i), sv[i]);
      h_exp = sv;
      run_cpu(MODE_SHA512_T, OFS_CONT, 32'hC000_0000);
   endtask
   task automatic run_dma(input logic [2:0] md, input logic [7:0] cmd, input logic [15:0] nb,
         input logic en);
      logic [31:0] r;
      logic [31:0] ch [16];
      int g, b, wpb;
      wpb = (md >= MODE_SHA384) ? 32 : 16;
      wr(OFS_MODE, {29'h0, md});
      wr(OFS_BLK_NUM, {16'h0, nb});
      wr(OFS_IRQ_ENABLE, {31'h0, en});
      for (int i = 0; i < 16; i++) ch[i] = (cmd == OFS_DMA_START) ? IV_K : h_exp[i];
      g = go_cnt;
      b = beats;
      wr(cmd, 32'h1);
      wait_idle();
      chk(32'(go_cnt - g), {16'h0, nb});
      chk(32'(beats - b), 32'(nb * wpb));
      for (int k = 0; k < nb; k++)
         for (int i = 0; i < 16; i++) ch[i] = ch[i] ^ 32'(32'hD000_0000 + b + wpb * k + i);
      for (int i = 0; i < nw[md]; i++) begin
         h_exp[i] = ch[i];
         rd(wa(8'h40, i), r);
         chk(r, h_exp[i]);
      end
      chk({31'h0, done_irq}, {31'h0, en});
      repeat (5) @(posedge core_clk);
      chk({31'h0, done_irq}, {31'h0, en});
      wr(OFS_IRQ_ENABLE, 32'h0);
      @(posedge core_clk);
      chk({31'h0, done_irq}, 32'h0);
      wr(OFS_IRQ_ENABLE, {31'h0, en});
      wr(OFS_IRQ_CLEAR, 32'h1);
      @(posedge core_clk);
      chk({31'h0, done_irq}, 32'h0);
   endtask
   // ********************
   // main sequence
   // ********************
   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_modes();
      run_cpu(MODE_SHA512_T, OFS_CONT, 32'h9000_0000);
      t_resume();
      run_dma(MODE_SHA256, OFS_DMA_START, 16'h2, 1'b1);
      for (int i = 0; i < 16; i++) begin
         h_exp[i] = 32'h2222_0000 + 32'(i);
         wr(wa(8'h40, i), h_exp[i]);
      end
      run_dma(MODE_SHA256, OFS_DMA_CONT, 16'h1, 1'b0);
      run_dma(MODE_SHA256, OFS_DMA_START, 16'h1, 1'b1);
      run_cpu(MODE_SHA512_T, OFS_START, 32'hE000_0000);
      run_dma(MODE_SHA512_T, OFS_DMA_CONT, 16'h2, 1'b1);
      stop_test();
   end
   // hang guard, well past the expected run length
   initial begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      stop_test();
   end
endmodule
